// ---- include/gdcs_pkg.sv ----
package gdcs_pkg;
   localparam int GDCS_CLK_HZ        = 50000000;
   localparam int GDCS_TIMEOUT_US    = 20;
   // Longest time rounds down
   localparam int GDCS_TIMEOUT_CYC   = GDCS_CLK_HZ / 1000000 * GDCS_TIMEOUT_US;
   localparam int GDCS_ADDR_W        = 18;
   localparam int GDCS_CNT_W         = 16;
   localparam int GDCS_TMR_W         = 10;
   localparam logic [GDCS_TMR_W-1:0] GDCS_TMR_LAST =
      GDCS_TMR_W'(GDCS_TIMEOUT_CYC - 1);
   localparam logic [GDCS_ADDR_W-1:0] GDCS_PTR_RST = 18'h00000;
   localparam logic [GDCS_CNT_W-1:0]  GDCS_CNT_RST = 16'h0000;
   localparam logic [GDCS_ADDR_W-1:0] GDCS_PTR_STEP = 18'h00001;

   typedef enum logic [3:0] {
      GDCS_S6, GDCS_S7, GDCS_S8, GDCS_S9, GDCS_S10,
      GDCS_S11, GDCS_S12, GDCS_S13, GDCS_S14, GDCS_S15
   } gdcs_state_type;
endpackage

// ---- src/gdcs_sequencer.sv ----
`timescale 1ns/1ps
// Overview of operation
// - State 9: SACK, wait NPG and BBSY negated
// - Burst hold with bus held: 7 to 10
// - State 10 drives pointer; read talking, write listening
// - State 10: BBSY, start timer, drop NPR
// - State 10 holds grant capture cleared
// - State 11: drop SACK, MSYN, await SSYN
// - Timeout without SSYN: error, stop transfer
// - Slow instrument timeout sets no error flag
// - Timer stopped at 12 unless burst hold
// - Cleared start lets timer expire, releasing BBSY
// - State 12: drop MSYN, clear valid or load buffer
// - State 12 sets complete on overflow or end
// - State 12 triggers source or acceptor handshake
// - Leaving 12 removes address and data
// - State 13 steps pointer once, then 14
// - State 14 counts bytes; packed to 6
// - Unpacked state 15 steps pointer again, to 6
// - Idle 6 starts on start plus ready
// - State 8 asserts NPR, waits for NPG
module gdcs_sequencer
   import gdcs_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Configuration, same clock domain
   input  wire logic                   start_set,
   input  wire logic                   burst_hold_mode,
   input  wire logic                   two_byte_word_mode,
   input  wire logic                   direction_to_memory,
   input  wire logic                   count_down,
   input  wire logic                   suppress_end_flag,
   input  wire logic                   end_seen_flag,
   input  wire logic                   talker_buffer_empty,
   input  wire logic                   listener_byte_valid,
   input  wire logic                   error_clear,
   input  wire logic                   ptr_load,
   input  wire logic [GDCS_ADDR_W-1:0] ptr_load_value,
   input  wire logic                   cnt_load,
   input  wire logic [GDCS_CNT_W-1:0]  cnt_load_value,
   // Host bus pins
   input  wire logic                   npg_in,
   input  wire logic                   bbsy_in,
   input  wire logic                   ssyn_in,
   input  wire logic [7:0]             host_data_in,
   output logic                        npr_out,
   output logic                        sack_out,
   output logic                        bbsy_out,
   output logic                        msyn_out,
   output logic [GDCS_ADDR_W-1:0]      host_addr_out,
   output logic                        host_addr_oe_n,
   output logic                        host_write_cycle,
   output logic                        host_data_oe_n,
   // Instrument bus side
   output logic [7:0]                  talker_buffer,
   output logic                        talker_load,
   output logic                        listener_clear,
   output logic                        source_start,
   output logic                        acceptor_start,
   // Status
   output logic                        start_transfer_bit,
   output logic                        transfer_complete_flag,
   output logic                        nonresponse_error_bit,
   output logic [GDCS_ADDR_W-1:0]      memory_pointer,
   output logic [GDCS_CNT_W-1:0]       byte_count,
   output logic                        count_overflow
);
   gdcs_state_type          state_ff;
   gdcs_state_type          nxt_state;
   logic                    npg_m_ff, npg_s_ff;
   logic                    bbsy_m_ff, bbsy_s_ff;
   logic                    ssyn_m_ff, ssyn_s_ff;
   logic                    grant_ff;
   logic                    npr_ff, sack_ff, bbsy_ff, msyn_ff;
   logic                    aoe_n_ff, doe_n_ff, wr_ff;
   logic [GDCS_ADDR_W-1:0]  addr_ff, ptr_ff;
   logic [GDCS_CNT_W-1:0]   cnt_ff;
   logic                    ovf_ff;
   logic [7:0]              tbuf_ff, data_m_ff, data_s_ff;
   logic                    tload_ff, lclr_ff, src_ff, acc_ff;
   logic                    go_ff, done_ff, err_ff;
   logic                    tmr_start, tmr_stop, tmr_run, tmr_exp;
   logic                    fail_now;
   logic [GDCS_ADDR_W-1:0]  ptr_step;

   assign npr_out                = npr_ff;
   assign sack_out               = sack_ff;
   assign bbsy_out               = bbsy_ff;
   assign msyn_out               = msyn_ff;
   assign host_addr_out          = addr_ff;
   assign host_addr_oe_n         = aoe_n_ff;
   assign host_write_cycle       = wr_ff;
   assign host_data_oe_n         = doe_n_ff;
   assign talker_buffer          = tbuf_ff;
   assign talker_load            = tload_ff;
   assign listener_clear         = lclr_ff;
   assign source_start           = src_ff;
   assign acceptor_start         = acc_ff;
   assign start_transfer_bit     = go_ff;
   assign transfer_complete_flag = done_ff;
   assign nonresponse_error_bit  = err_ff;
   assign memory_pointer         = ptr_ff;
   assign byte_count             = cnt_ff;
   assign count_overflow         = ovf_ff;

   // Bus pins are asynchronous to clk; data settles before SSYN is seen
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         {npg_m_ff, npg_s_ff}   <= 2'h0;
         {bbsy_m_ff, bbsy_s_ff} <= 2'h0;
         {ssyn_m_ff, ssyn_s_ff} <= 2'h0;
         {data_m_ff, data_s_ff} <= 16'h0000;
      end
      else
      begin
         npg_m_ff  <= npg_in;
         npg_s_ff  <= npg_m_ff;
         bbsy_m_ff <= bbsy_in;
         bbsy_s_ff <= bbsy_m_ff;
         ssyn_m_ff <= ssyn_in;
         ssyn_s_ff <= ssyn_m_ff;
         data_m_ff <= host_data_in;
         data_s_ff <= data_m_ff;
      end
   end

   gdcs_timer u_timer
   (
      .clk     (clk),
      .reset   (reset),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .running (tmr_run),
      .expired (tmr_exp)
   );

   assign tmr_start = (state_ff == GDCS_S10);
   assign tmr_stop  = (state_ff == GDCS_S12) && !burst_hold_mode;
   assign fail_now  = (state_ff == GDCS_S11) && tmr_exp && !ssyn_s_ff;
   assign ptr_step  = count_down ? ptr_ff - GDCS_PTR_STEP
                                 : ptr_ff + GDCS_PTR_STEP;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         GDCS_S6:
            if (go_ff && (direction_to_memory ? listener_byte_valid
                                              : talker_buffer_empty))
               nxt_state = GDCS_S7;
         GDCS_S7:
            nxt_state = (burst_hold_mode && bbsy_ff) ? GDCS_S10
                                                     : GDCS_S8;
         GDCS_S8:
            if (grant_ff)
               nxt_state = GDCS_S9;
         GDCS_S9:
            if (!npg_s_ff && !bbsy_s_ff)
               nxt_state = GDCS_S10;
         GDCS_S10: nxt_state = GDCS_S11;
         GDCS_S11:
            if (ssyn_s_ff || tmr_exp)
               nxt_state = GDCS_S12;
         GDCS_S12: nxt_state = GDCS_S13;
         GDCS_S13: nxt_state = GDCS_S14;
         GDCS_S14:
            nxt_state = two_byte_word_mode ? GDCS_S6 : GDCS_S15;
         GDCS_S15: nxt_state = GDCS_S6;
         default:  nxt_state = GDCS_S6;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         state_ff <= GDCS_S6;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         npr_ff   <= 1'b0;
         sack_ff  <= 1'b0;
         grant_ff <= 1'b0;
      end
      else
      begin
         if (state_ff == GDCS_S8)
            npr_ff <= 1'b1;
         else if (state_ff == GDCS_S10)
            npr_ff <= 1'b0;
         if (state_ff == GDCS_S9)
            sack_ff <= 1'b1;
         else if (state_ff == GDCS_S11)
            sack_ff <= 1'b0;
         // Others' grants must not be caught while we own the bus
         if (state_ff == GDCS_S10 || state_ff == GDCS_S6)
            grant_ff <= 1'b0;
         else if (state_ff == GDCS_S8 && npg_s_ff)
            grant_ff <= 1'b1;
      end
   end

   // Bus ownership; in burst hold BBSY is kept until timer lapses
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         bbsy_ff <= 1'b0;
      else if (state_ff == GDCS_S10)
         bbsy_ff <= 1'b1;
      else if (state_ff == GDCS_S6 && (!burst_hold_mode || !tmr_run))
         bbsy_ff <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         msyn_ff  <= 1'b0;
         addr_ff  <= GDCS_PTR_RST;
         aoe_n_ff <= 1'b1;
         doe_n_ff <= 1'b1;
         wr_ff    <= 1'b0;
      end
      else
      begin
         if (state_ff == GDCS_S10)
         begin
            addr_ff  <= ptr_ff;
            aoe_n_ff <= 1'b0;
            wr_ff    <= direction_to_memory;
            doe_n_ff <= !direction_to_memory;
         end
         else if (state_ff == GDCS_S12)
         begin
            aoe_n_ff <= 1'b1;
            doe_n_ff <= 1'b1;
         end
         if (state_ff == GDCS_S11)
            msyn_ff <= 1'b1;
         else if (state_ff == GDCS_S12)
            msyn_ff <= 1'b0;
      end
   end

   // Byte movement and handshake triggers, one-cycle pulses
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tbuf_ff  <= 8'h00;
         tload_ff <= 1'b0;
         lclr_ff  <= 1'b0;
         src_ff   <= 1'b0;
         acc_ff   <= 1'b0;
      end
      else
      begin
         tload_ff <= (state_ff == GDCS_S12) && !direction_to_memory;
         lclr_ff  <= (state_ff == GDCS_S12) && direction_to_memory;
         src_ff   <= (state_ff == GDCS_S12) && !direction_to_memory;
         acc_ff   <= (state_ff == GDCS_S12) && direction_to_memory;
         if (state_ff == GDCS_S12 && !direction_to_memory)
            tbuf_ff <= data_s_ff;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ptr_ff <= GDCS_PTR_RST;
      else if (ptr_load)
         ptr_ff <= ptr_load_value;
      else if (state_ff == GDCS_S13 || state_ff == GDCS_S15)
         ptr_ff <= ptr_step;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_ff <= GDCS_CNT_RST;
         ovf_ff <= 1'b0;
      end
      else if (cnt_load)
      begin
         cnt_ff <= cnt_load_value;
         ovf_ff <= 1'b0;
      end
      else if (state_ff == GDCS_S14 && !ovf_ff)
      begin
         cnt_ff <= cnt_ff + 1'b1;
         ovf_ff <= (cnt_ff == {GDCS_CNT_W{1'b1}});
      end
   end

   // Status flags; hardware set or clear wins over software clear or set
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         go_ff   <= 1'b0;
         done_ff <= 1'b0;
         err_ff  <= 1'b0;
      end
      else
      begin
         if (fail_now)
            err_ff <= 1'b1;
         else if (error_clear)
            err_ff <= 1'b0;
         if (state_ff == GDCS_S12)
            done_ff <= ovf_ff || (!suppress_end_flag && end_seen_flag);
         else if (start_set)
            done_ff <= 1'b0;
         if (fail_now || (state_ff == GDCS_S12 && (ovf_ff ||
             (!suppress_end_flag && end_seen_flag))))
            go_ff <= 1'b0;
         else if (start_set)
            go_ff <= 1'b1;
      end
   end

   sequence s_in_s10;
      state_ff == GDCS_S10;
   endsequence
   sequence s_then_s11_msyn;
      (state_ff == GDCS_S11) ##1 msyn_ff;
   endsequence

   a_s10_to_s11: assert property (@(posedge clk) disable iff (reset)
      s_in_s10 |=> s_then_s11_msyn)
      else $error("state 10 did not lead to 11 with MSYN");
   a_s9_waits_bus: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S9 && (npg_s_ff || bbsy_s_ff)) |=>
      state_ff == GDCS_S9)
      else $error("left state 9 while bus still busy");
   a_s9_sack_on: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S9) |=> sack_ff)
      else $error("SACK missing after state 9");
   a_hold_skip: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S7 && burst_hold_mode && bbsy_ff) |=>
      state_ff == GDCS_S10)
      else $error("burst hold did not skip arbitration");
   a_s10_grant_clear: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S10) |=> !grant_ff && bbsy_ff && !npr_ff)
      else $error("state 10 outputs wrong");
   a_timeout_error: assert property (@(posedge clk) disable iff (reset)
      fail_now |=> err_ff && !go_ff ##1 state_ff == GDCS_S13)
      else $error("timeout did not flag error");
   a_s12_release: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S12) |=> !msyn_ff && aoe_n_ff && doe_n_ff)
      else $error("bus not released after state 12");
   a_pack_branch: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S14) |=>
      state_ff == (two_byte_word_mode ? GDCS_S6 : GDCS_S15))
      else $error("wrong branch from state 14");
   a_ptr_step: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S13 && !ptr_load && !count_down) |=>
      ptr_ff == $past(ptr_ff) + GDCS_PTR_STEP)
      else $error("pointer not stepped in state 13");
   a_npr_in_s8: assert property (@(posedge clk) disable iff (reset)
      (state_ff == GDCS_S8) |=> npr_ff)
      else $error("NPR missing in state 8");
endmodule

// ---- src/gdcs_timer.sv ----
`timescale 1ns/1ps
// No-response timer: retriggerable only while idle, counts device clocks
module gdcs_timer
   import gdcs_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic start,
   input  wire logic stop,
   output logic      running,
   output logic      expired
);
   logic [GDCS_TMR_W-1:0] count_ff;
   logic                  run_ff;
   logic                  exp_ff;

   assign running = run_ff;
   assign expired = exp_ff;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         run_ff   <= 1'b0;
         count_ff <= '0;
         exp_ff   <= 1'b0;
      end
      else if (stop)
      begin
         run_ff <= 1'b0;
         exp_ff <= 1'b0;
      end
      else if (start && !run_ff)
      begin
         run_ff   <= 1'b1;
         count_ff <= '0;
         exp_ff   <= 1'b0;
      end
      else if (run_ff)
      begin
         if (count_ff == GDCS_TMR_LAST)
         begin
            run_ff <= 1'b0;
            exp_ff <= 1'b1;
         end
         else
            count_ff <= count_ff + 1'b1;
      end
   end
endmodule

// ---- testbench/gdcs_host_model.sv ----
`timescale 1ns/1ps
// Arbitrator plus one memory slave as seen from the host bus
module gdcs_host_model
   import gdcs_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   npr_out,
   input  wire logic                   sack_out,
   input  wire logic                   bbsy_out,
   input  wire logic                   msyn_out,
   input  wire logic [GDCS_ADDR_W-1:0] host_addr_out,
   input  wire logic                   host_addr_oe_n,
   input  wire logic                   other_bbsy,
   input  wire logic                   slave_mute,
   input  wire logic [3:0]             slave_delay,
   output logic                        npg_in,
   output logic                        bbsy_in,
   output logic                        ssyn_in,
   output logic [7:0]                  host_data_in
);
   logic [3:0] wait_ff;
   logic [7:0] word;

   // Wired line: busy from us or from another master
   assign bbsy_in = bbsy_out | other_bbsy;
   assign word = host_addr_out[7:0] ^ 8'h5A;
   // Released data lines float; inverse keeps stale bytes from matching
   assign host_data_in = ssyn_in ? word : ~word;

   // Grant regardless of bus busy; the requester must wait for it
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         npg_in <= 1'b0;
      else if (sack_out)
         npg_in <= 1'b0;
      else if (npr_out)
         npg_in <= 1'b1;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ssyn_in <= 1'b0;
         wait_ff <= 4'h0;
      end
      else if (!msyn_out || host_addr_oe_n)
      begin
         ssyn_in <= 1'b0;
         wait_ff <= 4'h0;
      end
      else if (!slave_mute && wait_ff == slave_delay)
         ssyn_in <= 1'b1;
      else if (wait_ff != 4'hF)
         wait_ff <= wait_ff + 4'h1;
   end
endmodule

// ---- testbench/gpib_dma_cycle_sequencer_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpib_dma_cycle_sequencer_bench
   import gdcs_pkg::*;
;
   // f holds listen, down, packed, end seen, suppress, complete
   typedef struct packed {
      logic [5:0]             f;
      logic [GDCS_ADDR_W-1:0] p0;
      logic [GDCS_ADDR_W-1:0] p1;
   } gdcs_row_type;
   gdcs_row_type rows [4] = '{
      '{6'h00, 18'h00100, 18'h00102}, '{6'h1E, 18'h00200, 18'h001FF},
      '{6'h2D, 18'h3FFFF, 18'h00000}, '{6'h30, 18'h00000, 18'h3FFFE}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start_set, burst_hold_mode, two_byte_word_mode, direction_to_memory;
   logic count_down, suppress_end_flag, end_seen_flag, talker_buffer_empty;
   logic listener_byte_valid, error_clear, ptr_load, cnt_load;
   logic other_bbsy, slave_mute, npr_d, cap_wr;
   logic [3:0] slave_delay;
   logic [GDCS_ADDR_W-1:0] ptr_load_value, host_addr_out, memory_pointer;
   logic [GDCS_ADDR_W-1:0] cap_addr;
   logic [GDCS_CNT_W-1:0] cnt_load_value, byte_count, exp_cnt;
   logic npg_in, bbsy_in, ssyn_in, npr_out, sack_out, bbsy_out, msyn_out;
   logic host_addr_oe_n, host_write_cycle, host_data_oe_n, count_overflow;
   logic [7:0] host_data_in, talker_buffer;
   logic talker_load, listener_clear, source_start, acceptor_start;
   logic start_transfer_bit, transfer_complete_flag, nonresponse_error_bit;
   int fails = 0;
   int num_checks = 0;
   int n_npr = 0;
   int n_src = 0;
   int n_acc = 0;
   int t0, s;

   gdcs_sequencer u_dut (
      .clk, .reset, .start_set, .burst_hold_mode, .two_byte_word_mode,
      .direction_to_memory, .count_down, .suppress_end_flag, .end_seen_flag,
      .talker_buffer_empty, .listener_byte_valid, .error_clear, .ptr_load,
      .ptr_load_value, .cnt_load, .cnt_load_value, .npg_in, .bbsy_in,
      .ssyn_in, .host_data_in, .npr_out, .sack_out, .bbsy_out, .msyn_out,
      .host_addr_out, .host_addr_oe_n, .host_write_cycle, .host_data_oe_n,
      .talker_buffer, .talker_load, .listener_clear, .source_start,
      .acceptor_start, .start_transfer_bit, .transfer_complete_flag,
      .nonresponse_error_bit, .memory_pointer, .byte_count, .count_overflow);

   gdcs_host_model u_host (
      .clk, .reset, .npr_out, .sack_out, .bbsy_out, .msyn_out,
      .host_addr_out, .host_addr_oe_n, .other_bbsy, .slave_mute,
      .slave_delay, .npg_in, .bbsy_in, .ssyn_in, .host_data_in);

   always #10 clk = ~clk;

   always @(posedge clk)
   begin
      npr_d <= npr_out;
      if (npr_out && !npr_d)
         n_npr <= n_npr + 1;
      if (source_start)
         n_src <= n_src + 1;
      if (acceptor_start)
         n_acc <= n_acc + 1;
      if (msyn_out)
      begin
         cap_addr <= host_addr_out;
         cap_wr <= host_write_cycle;
      end
      // Instrument side: load fills buffer, read drops byte valid
      if (talker_load)
         talker_buffer_empty <= 1'b0;
      if (listener_clear)
         listener_byte_valid <= 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic kick(input logic lst);
      @(posedge clk);
      start_set <= 1'b1;
      direction_to_memory <= lst;
      if (lst)
         listener_byte_valid <= 1'b1;
      else
         talker_buffer_empty <= 1'b1;
      @(posedge clk);
      start_set <= 1'b0;
   endtask

   // Wait for the byte handshake or an error, then 8 cycles for the return to idle
   task automatic finish();
      int h;
      h = n_src + n_acc;
      t0 = 0;
      while (n_src + n_acc == h && nonresponse_error_bit !== 1'b1
             && t0 < 3000)
      begin
         @(posedge clk);
         t0++;
      end
      if (t0 == 3000)
      begin
         fails++;
         print_verdict();
      end
      tick(8);
   endtask

   task automatic print_verdict();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      {start_set, burst_hold_mode, two_byte_word_mode, direction_to_memory,
       count_down, suppress_end_flag, end_seen_flag, talker_buffer_empty,
       listener_byte_valid, error_clear, ptr_load, cnt_load, other_bbsy,
       slave_mute} <= '0;
      ptr_load_value <= '0;
      cnt_load_value <= '0;
      slave_delay <= 4'h1;
      tick(12);
      reset <= 1'b0;
      tick(2);
      `CHK({npr_out, sack_out, bbsy_out, msyn_out, host_addr_oe_n,
           host_data_oe_n, start_transfer_bit}, 7'h06)
      exp_cnt = 16'h0000;
      talker_buffer_empty <= 1'b1;
      tick(30);
      `CHK(n_npr, 0)
      foreach (rows[k])
      begin
         @(posedge clk);
         {direction_to_memory, count_down, two_byte_word_mode,
          end_seen_flag, suppress_end_flag} <= rows[k].f[5:1];
         ptr_load <= 1'b1;
         ptr_load_value <= rows[k].p0;
         slave_delay <= 4'(k * 4);
         @(posedge clk);
         ptr_load <= 1'b0;
         s = n_src + 2 * n_acc;
         kick(rows[k].f[5]);
         finish();
         exp_cnt = exp_cnt + 16'h0001;
         `CHK(memory_pointer, rows[k].p1)
         `CHK(byte_count, exp_cnt)
         `CHK({cap_wr, cap_addr}, {rows[k].f[5], rows[k].p0})
         `CHK(transfer_complete_flag, rows[k].f[0])
         `CHK(start_transfer_bit, ~rows[k].f[0])
         `CHK({host_addr_oe_n, host_data_oe_n, msyn_out}, 3'h6)
         `CHK(bbsy_out, 1'b0)
         `CHK(n_src + 2 * n_acc - s, rows[k].f[5] ? 2 : 1)
         `CHK(rows[k].f[5] ? listener_byte_valid : talker_buffer_empty,
              1'b0)
         if (!rows[k].f[5])
            `CHK(talker_buffer, rows[k].p0[7:0] ^ 8'h5A)
      end
      // Another master still busy after the grant
      other_bbsy <= 1'b1;
      kick(1'b0);
      tick(40);
      `CHK({sack_out, msyn_out, bbsy_out}, 3'h4)
      other_bbsy <= 1'b0;
      finish();
      exp_cnt = exp_cnt + 16'h0001;
      `CHK(byte_count, exp_cnt)
      @(posedge clk);
      slave_mute <= 1'b1;
      kick(1'b0);
      finish();
      `CHK(t0 >= 1000 && t0 < 1100, 1'b1)
      `CHK({nonresponse_error_bit, start_transfer_bit, bbsy_out}, 3'h4)
      @(posedge clk);
      error_clear <= 1'b1;
      slave_mute <= 1'b0;
      @(posedge clk);
      error_clear <= 1'b0;
      tick(2);
      `CHK(nonresponse_error_bit, 1'b0)
      burst_hold_mode <= 1'b1;
      kick(1'b0);
      finish();
      `CHK(bbsy_out, 1'b1)
      s = n_npr;
      kick(1'b0);
      finish();
      `CHK(n_npr, s)
      tick(1100);
      `CHK({bbsy_out, nonresponse_error_bit}, 2'h0)
      kick(1'b0);
      finish();
      `CHK(n_npr, s + 1)
      cnt_load <= 1'b1;
      cnt_load_value <= 16'hFFFF;
      end_seen_flag <= 1'b0;
      @(posedge clk);
      cnt_load <= 1'b0;
      kick(1'b0);
      finish();
      `CHK({count_overflow, transfer_complete_flag, start_transfer_bit},
           3'h5)
      `CHK(byte_count, 16'h0000)
      kick(1'b0);
      finish();
      `CHK({count_overflow, transfer_complete_flag, start_transfer_bit},
           3'h6)
      `CHK(byte_count, 16'h0000)
      tick(1100);
      `CHK(bbsy_out, 1'b0)
      // Reset in the middle of a bus cycle
      kick(1'b0);
      tick(16);
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(2);
      `CHK({npr_out, sack_out, bbsy_out, msyn_out, host_addr_oe_n,
           host_data_oe_n, start_transfer_bit}, 7'h06)
      `CHK({memory_pointer, byte_count, transfer_complete_flag}, 35'h0)
      print_verdict();
   end
endmodule
